//--- include/pvsi_defs.svh
// Offsets, field positions, reset values and widths for the pixel sync block
`ifndef PVSI_DEFS_SVH
`define PVSI_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define PVSI_OFF_CONFIG 12'h000
`define PVSI_OFF_HS_DUR 12'h004
`define PVSI_OFF_VS_DUR 12'h008
`define PVSI_OFF_LINE_LEN 12'h00C
`define PVSI_OFF_LINE_CNT 12'h010
`define PVSI_OFF_HBLANK 12'h014
`define PVSI_OFF_SYNC_EN 12'h018
`define PVSI_OFF_START 12'h01C
`define PVSI_OFF_STATUS 12'h020
// ****************************************
// Configuration fields
// ****************************************
`define PVSI_CFG_DECOMP 0
`define PVSI_CFG_MODE444 1
`define PVSI_CFG_MASTER 3
`define PVSI_CFG_W 4
// ****************************************
// Status fields and reset values
// ****************************************
`define PVSI_ST_BUSY 0
`define PVSI_ST_DONE 1
`define PVSI_CFG_RST 4'h0
`define PVSI_DUR_RST 16'h0004
`define PVSI_LEN_RST 16'h0010
`define PVSI_ZERO32 32'h0000_0000
`define PVSI_ONE16 16'h0001
`define PVSI_ZERO16 16'h0000
`endif

//--- include/pvsi_pkg.sv
// Types shared by the pixel sync block
package pvsi_pkg;
  typedef enum logic [6:0] {
    PVSI_IDLE = 7'b000_0001,
    PVSI_VS_PULSE = 7'b000_0010,
    PVSI_VS_WAIT = 7'b000_0100,
    PVSI_HS_PULSE = 7'b000_1000,
    PVSI_HS_WAIT = 7'b001_0000,
    PVSI_ACTIVE = 7'b010_0000,
    PVSI_HBLANK = 7'b100_0000
  } pvsi_state_e;
endpackage

//--- design/pvsi_top.sv
// Video-side pixel interface: sync generation and detection, strobes, APB registers
//
// Operation
// - Output latch strobe low only on active reads
// - Freeze low holds every video-side output except the sync enables
// - Master mode drives line sync low pulse
// - Line sync width from its duration register
// - Slave mode: line sync is an input
// - Slave line sync taken on falling edge
// - Master frame sync pulse precedes each run
// - Slave frame sync taken on falling edge
// - Blanking changes with address, phase high
// - Compression: blanking high during written line
// - Decompression: blanking low during active reads
// - All video logic on the pixel clock
// - Phase high means write cycle, else read
// - Quarter-rate clock used only in 444 modes
// - Sixteen-bit strip address output
// - Input buffer enable low on active writes in compression only
`timescale 1ns/10ps
`include "pvsi_defs.svh"
module pvsi_top import pvsi_pkg::*; #(
  parameter int AW = 16,
  parameter int PW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic freeze_n,
  input wire logic strip_rw_phase,
  input wire logic quarter_rate_clock,
  output logic [AW-1:0] strip_address,
  input wire logic [PW-1:0] pixel_bus_i,
  output logic [PW-1:0] pixel_bus_o,
  output logic pixel_bus_oe,
  input wire logic [PW-1:0] core_pixel,
  output logic [PW-1:0] captured_pixel,
  output logic strip_read_enable_n,
  output logic strip_write_enable_n,
  output logic pixel_input_buffer_enable_n,
  output logic pixel_out_latch_n,
  output logic blank,
  input wire logic hsync_i,
  output logic hsync_o,
  output logic hsync_oe,
  input wire logic vsync_i,
  output logic vsync_o,
  output logic vsync_oe
);
  // ****************************************
  // Register file
  // ****************************************
  logic [`PVSI_CFG_W-1:0] cfg_r, cfg_nxt;
  logic [15:0] hs_dur_r, hs_dur_nxt, vs_dur_r, vs_dur_nxt;
  logic [15:0] line_len_r, line_len_nxt, line_cnt_r, line_cnt_nxt;
  logic [15:0] hblank_r, hblank_nxt;
  logic sync_en_r, sync_en_nxt, start_r, start_nxt, done_r, done_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic wr_hit, rd_hit, hit, run_end;
  pvsi_state_e st_r, st_nxt;

  assign hit = psel & penable & ~pready_r;
  assign wr_hit = hit & pwrite;
  assign rd_hit = hit & ~pwrite;

  // Decode; one wait state so every answer comes from a flop
  always_comb begin
    cfg_nxt = cfg_r;
    hs_dur_nxt = hs_dur_r;
    vs_dur_nxt = vs_dur_r;
    line_len_nxt = line_len_r;
    line_cnt_nxt = line_cnt_r;
    hblank_nxt = hblank_r;
    sync_en_nxt = sync_en_r;
    start_nxt = start_r;
    done_nxt = done_r;
    prdata_nxt = prdata_r;
    pready_nxt = hit;
    pslverr_nxt = 1'b0;
    if (st_r == PVSI_IDLE && start_r && sync_en_r && freeze_n) begin
      start_nxt = 1'b0; // Run launches, pending start consumed
    end
    if (wr_hit) begin
      unique case (paddr)
        `PVSI_OFF_CONFIG: cfg_nxt = pwdata[`PVSI_CFG_W-1:0];
        `PVSI_OFF_HS_DUR: hs_dur_nxt = pwdata[15:0];
        `PVSI_OFF_VS_DUR: vs_dur_nxt = pwdata[15:0];
        `PVSI_OFF_LINE_LEN: line_len_nxt = pwdata[15:0];
        `PVSI_OFF_LINE_CNT: line_cnt_nxt = pwdata[15:0];
        `PVSI_OFF_HBLANK: hblank_nxt = pwdata[15:0];
        `PVSI_OFF_SYNC_EN: sync_en_nxt = pwdata[0];
        `PVSI_OFF_START: begin
          start_nxt = pwdata[0];
          done_nxt = 1'b0;
        end
        `PVSI_OFF_STATUS: done_nxt = done_r & ~pwdata[`PVSI_ST_DONE];
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (rd_hit) begin
      prdata_nxt = `PVSI_ZERO32;
      unique case (paddr)
        `PVSI_OFF_CONFIG: prdata_nxt[`PVSI_CFG_W-1:0] = cfg_r;
        `PVSI_OFF_HS_DUR: prdata_nxt[15:0] = hs_dur_r;
        `PVSI_OFF_VS_DUR: prdata_nxt[15:0] = vs_dur_r;
        `PVSI_OFF_LINE_LEN: prdata_nxt[15:0] = line_len_r;
        `PVSI_OFF_LINE_CNT: prdata_nxt[15:0] = line_cnt_r;
        `PVSI_OFF_HBLANK: prdata_nxt[15:0] = hblank_r;
        `PVSI_OFF_SYNC_EN: prdata_nxt[0] = sync_en_r;
        `PVSI_OFF_START: prdata_nxt[0] = start_r;
        `PVSI_OFF_STATUS: begin
          prdata_nxt[`PVSI_ST_BUSY] = (st_r != PVSI_IDLE);
          prdata_nxt[`PVSI_ST_DONE] = done_r;
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (run_end) begin
      done_nxt = 1'b1; // Hardware set wins over a same-cycle clear
    end
  end

  // Register file flops; clock enable freezes them too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `PVSI_CFG_RST;
      hs_dur_r <= `PVSI_DUR_RST;
      vs_dur_r <= `PVSI_DUR_RST;
      line_len_r <= `PVSI_LEN_RST;
      line_cnt_r <= `PVSI_LEN_RST;
      hblank_r <= `PVSI_DUR_RST;
      sync_en_r <= 1'b0;
      start_r <= 1'b0;
      done_r <= 1'b0;
      prdata_r <= `PVSI_ZERO32;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      cfg_r <= cfg_nxt;
      hs_dur_r <= hs_dur_nxt;
      vs_dur_r <= vs_dur_nxt;
      line_len_r <= line_len_nxt;
      line_cnt_r <= line_cnt_nxt;
      hblank_r <= hblank_nxt;
      sync_en_r <= sync_en_nxt;
      start_r <= start_nxt;
      done_r <= done_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // Video side
  // ****************************************
  logic master, decomp, step, wr_slot, hs_fall, vs_fall, last_pix, last_line;
  logic [15:0] cnt_r, cnt_nxt, pix_r, pix_nxt, ln_r, ln_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [PW-1:0] pbo_r, pbo_nxt, cap_r, cap_nxt;
  logic pboe_r, pboe_nxt, re_n_r, re_n_nxt, we_n_r, we_n_nxt;
  logic in_n_r, in_n_nxt, out_n_r, out_n_nxt, blank_r, blank_nxt;
  logic hs_o_r, hs_o_nxt, vs_o_r, vs_o_nxt, hs_prev_r, vs_prev_r;

  assign master = cfg_r[`PVSI_CFG_MASTER];
  assign decomp = cfg_r[`PVSI_CFG_DECOMP];
  // Pixel step on write-phase edges; 444 modes also wait for the quarter clock
  assign step = strip_rw_phase & (~cfg_r[`PVSI_CFG_MODE444] | quarter_rate_clock);
  // Write cycle just ahead of a step edge; the quarter clock only moves on phase-high edges, so it is valid here
  assign wr_slot = ~strip_rw_phase & (~cfg_r[`PVSI_CFG_MODE444] | quarter_rate_clock);
  assign hs_fall = hs_prev_r & ~hsync_i;
  assign vs_fall = vs_prev_r & ~vsync_i;
  assign last_pix = (pix_r + `PVSI_ONE16) >= line_len_r;
  assign last_line = (ln_r + `PVSI_ONE16) >= line_cnt_r;
  assign run_end = clk_en & freeze_n & (st_nxt == PVSI_IDLE) & (st_r != PVSI_IDLE);

  // Sequencer and strobes; everything here sits still while frozen
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pix_nxt = pix_r;
    ln_nxt = ln_r;
    addr_nxt = addr_r;
    cap_nxt = cap_r;
    hs_o_nxt = 1'b1;
    vs_o_nxt = 1'b1;
    unique case (st_r)
      PVSI_IDLE: begin
        if (start_r && sync_en_r) begin
          cnt_nxt = `PVSI_ZERO16;
          ln_nxt = `PVSI_ZERO16;
          addr_nxt = '0;
          st_nxt = master ? PVSI_VS_PULSE : PVSI_VS_WAIT;
          vs_o_nxt = ~master;
        end
      end
      PVSI_VS_PULSE: begin
        cnt_nxt = cnt_r + `PVSI_ONE16;
        vs_o_nxt = 1'b0;
        if (cnt_nxt >= vs_dur_r) begin
          vs_o_nxt = 1'b1;
          hs_o_nxt = 1'b0;
          cnt_nxt = `PVSI_ZERO16;
          st_nxt = PVSI_HS_PULSE;
        end
      end
      PVSI_VS_WAIT: if (vs_fall) st_nxt = PVSI_HS_WAIT;
      PVSI_HS_PULSE: begin
        cnt_nxt = cnt_r + `PVSI_ONE16;
        hs_o_nxt = 1'b0;
        if (cnt_nxt >= hs_dur_r) begin
          hs_o_nxt = 1'b1;
          pix_nxt = `PVSI_ZERO16;
          st_nxt = PVSI_ACTIVE;
        end
      end
      PVSI_HS_WAIT: begin
        pix_nxt = `PVSI_ZERO16;
        if (hs_fall) st_nxt = PVSI_ACTIVE;
      end
      PVSI_ACTIVE: begin
        if (step) begin
          addr_nxt = addr_r + 1'b1;
          pix_nxt = pix_r + `PVSI_ONE16;
          if (!decomp) cap_nxt = pixel_bus_i;
          if (last_pix) begin
            cnt_nxt = `PVSI_ZERO16;
            st_nxt = PVSI_HBLANK;
          end
        end
      end
      PVSI_HBLANK: begin
        cnt_nxt = cnt_r + `PVSI_ONE16;
        if (!master || cnt_nxt >= hblank_r) begin
          cnt_nxt = `PVSI_ZERO16;
          ln_nxt = ln_r + `PVSI_ONE16;
          if (last_line) begin
            st_nxt = PVSI_IDLE;
          end else if (master) begin
            hs_o_nxt = 1'b0;
            st_nxt = PVSI_HS_PULSE;
          end else begin
            st_nxt = PVSI_HS_WAIT;
          end
        end
      end
    endcase
    // Write strobes cover the cycle before a step, read strobes the cycle after it: one pair per pixel
    we_n_nxt = ~((st_nxt == PVSI_ACTIVE) & wr_slot);
    re_n_nxt = ~((st_r == PVSI_ACTIVE) & step);
    in_n_nxt = ~((st_nxt == PVSI_ACTIVE) & ~decomp & wr_slot);
    out_n_nxt = ~((st_r == PVSI_ACTIVE) & decomp & step);
    pboe_nxt = (st_nxt == PVSI_ACTIVE) & decomp & wr_slot;
    pbo_nxt = pboe_nxt ? core_pixel : pbo_r;
    // Blanking moves only on phase-high edges, in step with the address
    blank_nxt = blank_r;
    if (strip_rw_phase) begin
      if (decomp) begin
        blank_nxt = (st_nxt != PVSI_ACTIVE);
      end else begin
        blank_nxt = (st_nxt == PVSI_ACTIVE);
      end
    end
  end

  // Video flops on the pixel clock; freeze gates every one so resume is exact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= PVSI_IDLE;
      cnt_r <= `PVSI_ZERO16;
      pix_r <= `PVSI_ZERO16;
      ln_r <= `PVSI_ZERO16;
      addr_r <= '0;
      cap_r <= '0;
      pbo_r <= '0;
      pboe_r <= 1'b0;
      re_n_r <= 1'b1;
      we_n_r <= 1'b1;
      in_n_r <= 1'b1;
      out_n_r <= 1'b1;
      blank_r <= 1'b1;
      hs_o_r <= 1'b1;
      vs_o_r <= 1'b1;
      hs_prev_r <= 1'b1;
      vs_prev_r <= 1'b1;
    end else if (clk_en && freeze_n) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pix_r <= pix_nxt;
      ln_r <= ln_nxt;
      addr_r <= addr_nxt;
      cap_r <= cap_nxt;
      pbo_r <= pbo_nxt;
      pboe_r <= pboe_nxt;
      re_n_r <= re_n_nxt;
      we_n_r <= we_n_nxt;
      in_n_r <= in_n_nxt;
      out_n_r <= out_n_nxt;
      blank_r <= blank_nxt;
      hs_o_r <= hs_o_nxt;
      vs_o_r <= vs_o_nxt;
      hs_prev_r <= hsync_i;
      vs_prev_r <= vsync_i;
    end
  end

  // Sync enables follow the master bit, a register output
  assign hsync_oe = master;
  assign vsync_oe = master;
  assign hsync_o = hs_o_r;
  assign vsync_o = vs_o_r;
  assign strip_address = addr_r;
  assign pixel_bus_o = pbo_r;
  assign pixel_bus_oe = pboe_r;
  assign captured_pixel = cap_r;
  assign strip_read_enable_n = re_n_r;
  assign strip_write_enable_n = we_n_r;
  assign pixel_input_buffer_enable_n = in_n_r;
  assign pixel_out_latch_n = out_n_r;
  assign blank = blank_r;
endmodule

//--- testbench/pvsi_top_asserts.sv
// Port-level checker for the pixel sync block
`timescale 1ns/10ps
`include "pvsi_defs.svh"
module pvsi_top_asserts #(
  parameter int AW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic freeze_n,
  input wire logic strip_rw_phase,
  input wire logic [AW-1:0] strip_address,
  input wire logic strip_read_enable_n,
  input wire logic strip_write_enable_n,
  input wire logic pixel_input_buffer_enable_n,
  input wire logic pixel_out_latch_n,
  input wire logic blank,
  input wire logic hsync_o,
  input wire logic hsync_oe,
  input wire logic vsync_o,
  input wire logic vsync_oe
);
  logic [15:0] hs_dur_r;
  logic [15:0] hs_low_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the line sync width; the low run only counts advancing cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_dur_r <= `PVSI_DUR_RST;
      hs_low_r <= 16'h0000;
    end else if (clk_en) begin
      if (psel && penable && pready && pwrite && paddr == `PVSI_OFF_HS_DUR) hs_dur_r <= pwdata[15:0];
      if (freeze_n) hs_low_r <= hsync_o ? 16'h0000 : hs_low_r + 16'h0001;
    end
  end
  sequence s_hs_end;
    $rose(hsync_o);
  endsequence
  property p_hs_width;
    s_hs_end |-> hs_low_r == ((hs_dur_r == 16'h0000) ? 16'h0001 : hs_dur_r);
  endproperty
  a_hs_width: assert property (p_hs_width) else $error("line sync width wrong");
  property p_sync_dir;
    !hsync_o |-> hsync_oe;
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("line sync pulse in slave mode");
  property p_vs_first;
    !vsync_o |-> (hsync_o && vsync_oe);
  endproperty
  a_vs_first: assert property (p_vs_first) else $error("frame sync overlaps line sync");
  property p_latch_rd;
    !pixel_out_latch_n |-> strip_write_enable_n;
  endproperty
  a_latch_rd: assert property (p_latch_rd) else $error("output latch on a write");
  property p_in_wr;
    !pixel_input_buffer_enable_n |-> !strip_write_enable_n;
  endproperty
  a_in_wr: assert property (p_in_wr) else $error("input buffer without write");
  property p_rw_excl;
    !(!strip_read_enable_n && !strip_write_enable_n);
  endproperty
  a_rw_excl: assert property (p_rw_excl) else $error("read and write together");
  property p_freeze;
    (!freeze_n && clk_en) |=> $stable({strip_address, blank, hsync_o, vsync_o, strip_read_enable_n,
      strip_write_enable_n, pixel_input_buffer_enable_n, pixel_out_latch_n});
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved while frozen");
  property p_blank_ph;
    $changed(blank) |-> $past(strip_rw_phase);
  endproperty
  a_blank_ph: assert property (p_blank_ph) else $error("blanking moved off phase");
endmodule
bind pvsi_top pvsi_top_asserts #(.AW(AW)) u_chk (.*);

//--- testbench/pvsi_partner.sv
// Pixel source and sync driver at the far side of the block
`timescale 1ns/10ps
module pvsi_partner #(
  parameter int AW = 16,
  parameter int PW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [AW-1:0] strip_address,
  input wire logic pixel_input_buffer_enable_n,
  output logic strip_rw_phase,
  output logic quarter_rate_clock,
  output logic [PW-1:0] pixel_src,
  output logic hsync_drv,
  output logic vsync_drv
);
  // Phase at half rate, quarter clock at half the phase rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strip_rw_phase <= 1'b0;
      quarter_rate_clock <= 1'b0;
    end else begin
      strip_rw_phase <= !strip_rw_phase;
      if (strip_rw_phase) quarter_rate_clock <= !quarter_rate_clock;
    end
  end
  // Off the buffer the bus toggles, so a stale pixel never looks valid
  assign pixel_src = pixel_input_buffer_enable_n ? {PW{strip_rw_phase}} : PW'(strip_address) ^ 24'hA5_0000;
  initial begin
    hsync_drv = 1'b1;
    vsync_drv = 1'b1;
  end
  // Slave sync pulse after a gap; a long gap plays a slow source
  task automatic pulse(input logic v, input int gap);
    repeat (gap) @(posedge pclk);
    if (v) vsync_drv <= 1'b0; else hsync_drv <= 1'b0;
    repeat (2) @(posedge pclk);
    vsync_drv <= 1'b1;
    hsync_drv <= 1'b1;
  endtask
endmodule

//--- testbench/pixel_video_sync_interface_tb.sv
// Self-checking bench for the pixel sync block
`timescale 1ns/10ps
`include "pvsi_defs.svh"
module pixel_video_sync_interface_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic freeze_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata_q;
  logic [15:0] strip_address;
  logic [23:0] pixel_bus_i, pixel_bus_o, pix_src, core_pixel, captured_pixel;
  logic pready, pslverr, err_q, strip_rw_phase, quarter_rate_clock, pixel_bus_oe, blank, hs_drv, vs_drv;
  logic strip_read_enable_n, strip_write_enable_n, pixel_input_buffer_enable_n, pixel_out_latch_n;
  logic hsync_o, hsync_oe, vsync_o, vsync_oe, hsync_w, vsync_w;
  int errors, n_compared, n_in, n_out, n_vs, n_hs;
  always #4 pclk = ~pclk;
  // Shared wires: whoever enables drives, the partner otherwise
  assign pixel_bus_i = pixel_bus_oe ? pixel_bus_o : pix_src;
  assign hsync_w = hsync_oe ? hsync_o : hs_drv;
  assign vsync_w = vsync_oe ? vsync_o : vs_drv;
  assign core_pixel = {8'h5A, strip_address};
  pvsi_top dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .freeze_n, .strip_rw_phase, .quarter_rate_clock, .strip_address, .pixel_bus_i,
    .pixel_bus_o, .pixel_bus_oe, .core_pixel, .captured_pixel, .strip_read_enable_n, .strip_write_enable_n,
    .pixel_input_buffer_enable_n, .pixel_out_latch_n, .blank, .hsync_i(hsync_w), .hsync_o, .hsync_oe,
    .vsync_i(vsync_w), .vsync_o, .vsync_oe);
  pvsi_partner u_part (.pclk, .presetn, .strip_address, .pixel_input_buffer_enable_n, .strip_rw_phase,
    .quarter_rate_clock, .pixel_src(pix_src), .hsync_drv(hs_drv), .vsync_drv(vs_drv));
  // Count only cycles the block advanced through, so a freeze adds nothing
  always @(posedge pclk) if (freeze_n) begin
    n_in += (pixel_input_buffer_enable_n === 1'b0);
    n_out += (pixel_out_latch_n === 1'b0);
    n_vs += (vsync_o === 1'b0);
    n_hs += (hsync_o === 1'b0);
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, then an idle cycle so psel is never set twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) errors++;
    @(posedge pclk);
  endtask
  task automatic cfg(input logic [31:0] mode, input logic [31:0] lines);
    apb(1'b1, `PVSI_OFF_CONFIG, mode);
    apb(1'b1, `PVSI_OFF_HS_DUR, 32'h3);
    apb(1'b1, `PVSI_OFF_VS_DUR, 32'h2);
    apb(1'b1, `PVSI_OFF_LINE_LEN, 32'h2);
    apb(1'b1, `PVSI_OFF_LINE_CNT, lines);
    apb(1'b1, `PVSI_OFF_HBLANK, 32'h2);
    apb(1'b1, `PVSI_OFF_SYNC_EN, 32'h0);
    apb(1'b1, `PVSI_OFF_START, 32'h1);
    apb(1'b0, `PVSI_OFF_START, 32'h0);
    chk("start pending", 32'h1, rdata_q);
    {n_in, n_out, n_vs, n_hs} = '0;
    apb(1'b1, `PVSI_OFF_SYNC_EN, 32'h1);
  endtask
  task automatic wait_done();
    rdata_q = 32'h0;
    for (int k = 0; k < 300 && rdata_q[`PVSI_ST_DONE] !== 1'b1; k++) apb(1'b0, `PVSI_OFF_STATUS, 32'h0);
    chk("done", 32'h1, rdata_q[`PVSI_ST_DONE]);
  endtask
  task automatic t_regs();
    apb(1'b0, `PVSI_OFF_HS_DUR, 32'h0);
    chk("hs_dur reset", `PVSI_DUR_RST, rdata_q);
    apb(1'b0, `PVSI_OFF_LINE_LEN, 32'h0);
    chk("line_len reset", `PVSI_LEN_RST, rdata_q);
    apb(1'b1, 12'h030, 32'hFFFF_FFFF);
    chk("unmapped err", 32'h1, err_q);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped data", 32'h0, rdata_q);
    $display("t_regs finished");
  endtask
  // Master compression run of two lines, frozen in mid-line
  task automatic t_master();
    logic [15:0] a;
    cfg(32'h8, 32'h2);
    for (int k = 0; k < 300 && n_in == 0; k++) @(posedge pclk);
    freeze_n <= 1'b0;
    @(posedge pclk);
    a = strip_address;
    repeat (5) @(posedge pclk);
    chk("frozen address", a, strip_address);
    freeze_n <= 1'b1;
    wait_done();
    chk("vsync_oe", 32'h1, vsync_oe);
    chk("frame sync cycles", 32'h2, n_vs);
    chk("line sync cycles", 32'h6, n_hs);
    chk("input strobes", 32'h4, n_in);
    chk("captured pixel", 32'h00A5_0003, captured_pixel);
    chk("final address", 32'h4, strip_address);
    chk("blank idle compress", 32'h0, blank);
    $display("t_master finished");
  endtask
  // Slave decompression run of one line in 444 mode with a slow source
  task automatic t_slave();
    cfg(32'h3, 32'h1);
    chk("hsync_oe", 32'h0, hsync_oe);
    repeat (20) @(posedge pclk);
    chk("idle before frame sync", 32'h0, n_out);
    u_part.pulse(1'b1, 3);
    u_part.pulse(1'b0, 12);
    wait_done();
    chk("output latch strobes", 32'h2, n_out);
    chk("pixel bus out", 32'h005A_0001, pixel_bus_o);
    chk("blank idle decompress", 32'h1, blank);
    chk("no line sync driven", 32'h0, n_hs);
    $display("t_slave finished");
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_master();
    t_slave();
    stop_test();
  end
  // Watchdog: the tests need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    stop_test();
  end
endmodule
